// file: rtl/lbc_top.sv
// Command decoder, clock-enable power sequencer and write-data mask tracker
`timescale 1ns/100ps
`default_nettype none
module lbc_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic memCke,
    input wire logic memCsN,
    input wire logic memRasN,
    input wire logic memCasN,
    input wire logic memWeN,
    input wire logic [1:0] memBank,
    input wire logic [12:0] memAddr,
    input wire logic memDm,
    output logic [2:0] powerState,
    output logic [11:0] bankStates,
    output logic inputsEnabled,
    output logic cmdValid,
    output logic [3:0] cmdCode,
    output logic cmdIllegal,
    output logic writeMasked,
    output logic burstActive
);
    // Pin synchronisers: two flops each before any logic looks at a pin
    // Reset loads deselect with clock enable high, so no false command or power-down follows reset
    logic [20:0] pinMeta_reg, pinSync_reg;
    logic ckeS;
    logic dmS;
    logic [1:0] bankS;
    logic [12:0] addrS;
    logic [3:0] strb;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_reg <= lbc_pkg::PIN_SYNC_RST;
            pinSync_reg <= lbc_pkg::PIN_SYNC_RST;
        end else begin
            pinMeta_reg <= {memCke, memDm, memBank, memAddr, memCsN, memRasN, memCasN, memWeN};
            pinSync_reg <= pinMeta_reg;
        end
    end

    // Synchronised pin fields; all of them share one two-flop delay, so a command stays aligned
    assign ckeS = pinSync_reg[20];
    assign dmS = pinSync_reg[19];
    assign bankS = pinSync_reg[18:17];
    assign addrS = pinSync_reg[16:4];
    assign strb = pinSync_reg[3:0]; // Chip select, row, column, write enable

    // Command decode from chip select, row, column and write strobes
    // Any pattern with chip select high falls to deselect
    lbc_pkg::lbc_cmd_e dec;
    always_comb begin
        unique case (strb)
            4'h7: dec = lbc_pkg::CMD_NOP;
            4'h3: dec = lbc_pkg::CMD_ACTIVE;
            4'h1: dec = lbc_pkg::CMD_REFRESH;
            4'h0: dec = lbc_pkg::CMD_LOAD_MODE;
            4'h5: dec = lbc_pkg::CMD_READ;
            4'h4: dec = lbc_pkg::CMD_WRITE;
            4'h2: dec = lbc_pkg::CMD_PRECHARGE;
            4'h6: dec = lbc_pkg::CMD_BURST_STOP;
            default: dec = lbc_pkg::CMD_DESELECT;
        endcase
    end

    // Previous clock-enable sample for the current/previous comparison
    logic ckePrev_reg, ckePrev_next;
    lbc_pkg::lbc_pwr_e pwr_reg, pwr_next;
    logic [3:0] pwrCnt_reg, pwrCnt_next;
    logic allIdle, anyBurst, isNopDes, bankIllegalAny;
    logic anyWrite;
    logic highHigh;
    logic lowHigh;
    logic highLow;
    lbc_pkg::lbc_bank_e bankState [lbc_pkg::NUM_BANKS];
    logic [lbc_pkg::NUM_BANKS-1:0] bankIllegal;
    logic [11:0] bankPacked;

    // Registered status outputs and their next values
    logic cmdValid_reg, cmdValid_next;
    logic [3:0] cmdCode_reg, cmdCode_next;
    logic cmdIllegal_reg, cmdIllegal_next;
    logic writeMasked_reg, writeMasked_next;
    logic burstActive_reg, burstActive_next;

    // Shared command carrier to the four bank trackers
    lbc_cmd_if cmdIf ();

    // Clock-enable history: previous and current samples
    assign isNopDes = (dec == lbc_pkg::CMD_NOP) || (dec == lbc_pkg::CMD_DESELECT);
    assign highHigh = ckePrev_reg && ckeS;
    assign lowHigh = !ckePrev_reg && ckeS;
    assign highLow = ckePrev_reg && !ckeS;

    // Banks hear commands only in normal running with clock enable high at both edges;
    // anything seen while powered down or mid-transition is dropped on purpose
    assign cmdIf.cmdEnable = (pwr_reg == lbc_pkg::PWR_NORMAL) && highHigh;
    assign cmdIf.cmd = dec;
    assign cmdIf.bank = bankS;
    assign cmdIf.allBanks = addrS[lbc_pkg::AP_BIT];

    // One tracker per bank, all on the same carrier
    for (genvar i = 0; i < lbc_pkg::NUM_BANKS; i++) begin : g_bank
        lbc_bank #(
            .BANK_ID(2'(i))
        ) i_bank (
            .clk(clk),
            .rst_n(rst_n),
            .cmdIf(cmdIf),
            .state(bankState[i]),
            .illegal(bankIllegal[i])
        );
    end

    // Summary of all banks: idle, bursting, writing, and the packed state word
    always_comb begin
        allIdle = 1'b1;
        anyBurst = 1'b0;
        anyWrite = 1'b0;
        bankPacked = 12'h000;
        for (int i = 0; i < lbc_pkg::NUM_BANKS; i++) begin
            bankPacked[3*i +: 3] = bankState[i];
            if (bankState[i] != lbc_pkg::BANK_IDLE) begin
                allIdle = 1'b0;
            end
            if (bankState[i] == lbc_pkg::BANK_READ || bankState[i] == lbc_pkg::BANK_WRITE) begin
                anyBurst = 1'b1;
            end
            if (bankState[i] == lbc_pkg::BANK_WRITE) begin
                anyWrite = 1'b1;
            end
        end
    end

    assign bankIllegalAny = |bankIllegal;

    // Power sequencer next state from the clock-enable pair and the current command
    always_comb begin
        pwr_next = pwr_reg;
        pwrCnt_next = (pwrCnt_reg != 4'h0) ? pwrCnt_reg - 4'h1 : 4'h0;
        ckePrev_next = ckeS;
        unique case (pwr_reg)
            lbc_pkg::PWR_NORMAL: begin
                if (highLow) begin
                    if (dec == lbc_pkg::CMD_REFRESH && allIdle) begin
                        pwr_next = lbc_pkg::PWR_SELF_REF;
                    end else if (isNopDes && allIdle) begin
                        pwr_next = lbc_pkg::PWR_PRE_PD;
                    end else if (isNopDes) begin
                        pwr_next = lbc_pkg::PWR_ACT_PD;
                    end
                end else if (highHigh && dec == lbc_pkg::CMD_REFRESH) begin
                    pwr_next = lbc_pkg::PWR_REFRESHING;
                    pwrCnt_next = lbc_pkg::TRFC_CLKS;
                end else if (highHigh && dec == lbc_pkg::CMD_LOAD_MODE) begin
                    pwr_next = lbc_pkg::PWR_MODE_LOAD;
                    pwrCnt_next = lbc_pkg::TMRD_CLKS;
                end
            end
            lbc_pkg::PWR_PRE_PD, lbc_pkg::PWR_ACT_PD: begin
                // Low-low keeps the state; only a rise with NOP or deselect leaves it
                if (lowHigh && isNopDes) begin
                    pwr_next = lbc_pkg::PWR_PD_EXIT;
                    pwrCnt_next = lbc_pkg::TPDX_CLKS;
                end
            end
            lbc_pkg::PWR_SELF_REF: begin
                if (lowHigh && isNopDes) begin
                    pwr_next = lbc_pkg::PWR_SR_EXIT;
                    pwrCnt_next = lbc_pkg::TXSR_CLKS;
                end
            end
            lbc_pkg::PWR_PD_EXIT, lbc_pkg::PWR_SR_EXIT, lbc_pkg::PWR_REFRESHING, lbc_pkg::PWR_MODE_LOAD: begin
                // Timed states: commands are not passed on until the count runs out
                if (pwrCnt_reg <= 4'h1) begin
                    pwr_next = lbc_pkg::PWR_NORMAL;
                end
            end
        endcase
    end

    // Power sequencer registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_reg <= lbc_pkg::PWR_NORMAL;
            pwrCnt_reg <= 4'h0;
            ckePrev_reg <= 1'b1;
        end else begin
            pwr_reg <= pwr_next;
            pwrCnt_reg <= pwrCnt_next;
            ckePrev_reg <= ckePrev_next;
        end
    end

    // Status next values; a command counts as taken when the previous clock enable was high,
    // so the refresh that enters self refresh is reported as well
    always_comb begin
        cmdValid_next = (pwr_reg == lbc_pkg::PWR_NORMAL) && ckePrev_reg && (dec != lbc_pkg::CMD_DESELECT);
        cmdCode_next = dec;
        cmdIllegal_next = bankIllegalAny
            || (cmdIf.cmdEnable && !allIdle && (dec == lbc_pkg::CMD_REFRESH || dec == lbc_pkg::CMD_LOAD_MODE));
        writeMasked_next = anyWrite && dmS; // Mask seen while a write burst runs
        burstActive_next = anyBurst;
    end

    // Status registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdValid_reg <= 1'b0;
            cmdCode_reg <= 4'h0;
            cmdIllegal_reg <= 1'b0;
            writeMasked_reg <= 1'b0;
            burstActive_reg <= 1'b0;
        end else begin
            cmdValid_reg <= cmdValid_next;
            cmdCode_reg <= cmdCode_next;
            cmdIllegal_reg <= cmdIllegal_next;
            writeMasked_reg <= writeMasked_next;
            burstActive_reg <= burstActive_next;
        end
    end

    // Outputs; input buffers are off in every low-power state
    assign powerState = pwr_reg;
    assign bankStates = bankPacked;
    assign inputsEnabled = !(pwr_reg inside {lbc_pkg::PWR_PRE_PD, lbc_pkg::PWR_ACT_PD, lbc_pkg::PWR_SELF_REF});
    assign cmdValid = cmdValid_reg;
    assign cmdCode = cmdCode_reg;
    assign cmdIllegal = cmdIllegal_reg;
    assign writeMasked = writeMasked_reg;
    assign burstActive = burstActive_reg;
endmodule : lbc_top
`default_nettype wire

// file: rtl/lbc_pkg.sv
// Package of constants and types for the bank command and power-down sequencer
package lbc_pkg;
    localparam int NUM_BANKS = 4;
    localparam int ROW_W = 13;
    localparam int AP_BIT = 10;
    // Burst length in data elements and its clock count (two elements per clock)
    localparam logic [4:0] BURST_LEN = 5'h04;
    localparam logic [3:0] BURST_CLKS = 4'h2;
    // Postamble and timing figures, in clocks at 20 MHz (50 ns period)
    localparam int CLK_NS = 50;
    localparam int TRP_NS = 15;
    localparam int TRFC_NS = 72;
    localparam int TMRD_NS = 10;
    localparam int TPDX_NS = 6;
    localparam int TXSR_NS = 112;
    localparam logic [3:0] POST_CLKS = 4'h1;
    localparam logic [3:0] TRP_CLKS = 4'((TRP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] TRFC_CLKS = 4'((TRFC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] TMRD_CLKS = 4'((TMRD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] TPDX_CLKS = 4'((TPDX_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] TXSR_CLKS = 4'((TXSR_NS + CLK_NS - 1) / CLK_NS);
    // Synchroniser reset: clock enable high, strobes all high (deselect)
    localparam logic [20:0] PIN_SYNC_RST = 21'h10000F;

    // Decoded commands
    typedef enum logic [3:0] {
        CMD_DESELECT = 4'h0,
        CMD_NOP = 4'h1,
        CMD_ACTIVE = 4'h2,
        CMD_REFRESH = 4'h3,
        CMD_LOAD_MODE = 4'h4,
        CMD_READ = 4'h5,
        CMD_WRITE = 4'h6,
        CMD_PRECHARGE = 4'h7,
        CMD_BURST_STOP = 4'h8
    } lbc_cmd_e;

    // Per-bank states
    typedef enum logic [2:0] {
        BANK_IDLE = 3'h0,
        BANK_ACTIVE = 3'h1,
        BANK_READ = 3'h2,
        BANK_WRITE = 3'h3,
        BANK_PRECHARGING = 3'h4
    } lbc_bank_e;

    // Device-wide power states
    typedef enum logic [2:0] {
        PWR_NORMAL = 3'h0,
        PWR_PRE_PD = 3'h1,
        PWR_ACT_PD = 3'h2,
        PWR_SELF_REF = 3'h3,
        PWR_PD_EXIT = 3'h4,
        PWR_SR_EXIT = 3'h5,
        PWR_REFRESHING = 3'h6,
        PWR_MODE_LOAD = 3'h7
    } lbc_pwr_e;
endpackage : lbc_pkg

// file: rtl/lbc_cmd_if.sv
// Interface carrying a decoded command from the top to the bank trackers
`timescale 1ns/100ps
`default_nettype none
interface lbc_cmd_if;
    lbc_pkg::lbc_cmd_e cmd;
    logic [1:0] bank;
    logic allBanks;
    logic cmdEnable;
    modport src (output cmd, output bank, output allBanks, output cmdEnable);
    modport dst (input cmd, input bank, input allBanks, input cmdEnable);
endinterface : lbc_cmd_if
`default_nettype wire

// file: rtl/lbc_bank.sv
// One bank's state tracker: idle, active, reading, writing, precharging
`timescale 1ns/100ps
`default_nettype none
module lbc_bank #(
    parameter logic [1:0] BANK_ID = 2'h0
) (
    input wire logic clk,
    input wire logic rst_n,
    lbc_cmd_if.dst cmdIf,
    output lbc_pkg::lbc_bank_e state,
    output logic illegal
);
    lbc_pkg::lbc_bank_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic hit;
    logic isPre;

    assign hit = cmdIf.cmdEnable && (cmdIf.bank == BANK_ID);
    assign isPre = cmdIf.cmdEnable && cmdIf.cmd == lbc_pkg::CMD_PRECHARGE && (cmdIf.allBanks || hit);

    // Next bank state from the command and the burst / precharge counter
    always_comb begin
        state_next = state_reg;
        cnt_next = (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : 4'h0;
        illegal = 1'b0;
        unique case (state_reg)
            lbc_pkg::BANK_IDLE: begin
                if (hit && cmdIf.cmd == lbc_pkg::CMD_ACTIVE) begin
                    state_next = lbc_pkg::BANK_ACTIVE;
                end else if (hit && (cmdIf.cmd == lbc_pkg::CMD_READ || cmdIf.cmd == lbc_pkg::CMD_WRITE)) begin
                    illegal = 1'b1;
                end
            end
            lbc_pkg::BANK_ACTIVE: begin
                if (isPre) begin
                    state_next = lbc_pkg::BANK_PRECHARGING;
                    cnt_next = lbc_pkg::TRP_CLKS;
                end else if (hit && cmdIf.cmd == lbc_pkg::CMD_READ) begin
                    state_next = lbc_pkg::BANK_READ;
                    cnt_next = lbc_pkg::BURST_CLKS + lbc_pkg::POST_CLKS;
                end else if (hit && cmdIf.cmd == lbc_pkg::CMD_WRITE) begin
                    state_next = lbc_pkg::BANK_WRITE;
                    cnt_next = lbc_pkg::BURST_CLKS + lbc_pkg::POST_CLKS;
                end else if (hit && cmdIf.cmd == lbc_pkg::CMD_ACTIVE) begin
                    illegal = 1'b1;
                end
            end
            lbc_pkg::BANK_READ, lbc_pkg::BANK_WRITE: begin
                if (isPre) begin
                    state_next = lbc_pkg::BANK_PRECHARGING;
                    cnt_next = lbc_pkg::TRP_CLKS;
                end else if (hit && cmdIf.cmd == lbc_pkg::CMD_READ) begin
                    state_next = lbc_pkg::BANK_READ;
                    cnt_next = lbc_pkg::BURST_CLKS + lbc_pkg::POST_CLKS;
                end else if (hit && cmdIf.cmd == lbc_pkg::CMD_WRITE) begin
                    state_next = lbc_pkg::BANK_WRITE;
                    cnt_next = lbc_pkg::BURST_CLKS + lbc_pkg::POST_CLKS;
                end else if (hit && cmdIf.cmd == lbc_pkg::CMD_ACTIVE) begin
                    illegal = 1'b1;
                end else if (cmdIf.cmdEnable && cmdIf.cmd == lbc_pkg::CMD_BURST_STOP
                             && state_reg == lbc_pkg::BANK_READ) begin
                    state_next = lbc_pkg::BANK_ACTIVE;
                end else if (cnt_reg == 4'h1) begin
                    state_next = lbc_pkg::BANK_ACTIVE;
                end
            end
            lbc_pkg::BANK_PRECHARGING: begin
                if (hit && cmdIf.cmd != lbc_pkg::CMD_DESELECT && cmdIf.cmd != lbc_pkg::CMD_NOP) begin
                    illegal = 1'b1;
                end
                if (cnt_reg <= 4'h1) begin
                    state_next = lbc_pkg::BANK_IDLE;
                end
            end
            default: begin
                state_next = lbc_pkg::BANK_IDLE;
            end
        endcase
    end

    // Bank state registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= lbc_pkg::BANK_IDLE;
            cnt_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    assign state = state_reg;
endmodule : lbc_bank
`default_nettype wire

// file: dv/lbc_assertions.sv
// Port-level checks of the bank and power sequencer
`timescale 1ns/100ps
`default_nettype none
module lbc_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic memCke,
    input wire logic memCsN,
    input wire logic memRasN,
    input wire logic memCasN,
    input wire logic memWeN,
    input wire logic [1:0] memBank,
    input wire logic [12:0] memAddr,
    input wire logic memDm,
    input wire logic [2:0] powerState,
    input wire logic [11:0] bankStates,
    input wire logic inputsEnabled,
    input wire logic cmdValid,
    input wire logic [3:0] cmdCode,
    input wire logic cmdIllegal,
    input wire logic writeMasked,
    input wire logic burstActive
);
    logic [3:0] pins;
    logic run;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Strobe pattern, and normal running with clock enable high
    assign pins = {memCsN, memRasN, memCasN, memWeN};
    assign run = powerState == lbc_pkg::PWR_NORMAL && memCke;
    pd_entry_a: assert property (run && bankStates == 12'h000 ##1 !memCke && pins == 4'h7
        |-> ##[1:3] powerState == lbc_pkg::PWR_PRE_PD) else $error("no idle power-down");
    act_pd_a: assert property (run && bankStates == 12'h001 ##1 !memCke && pins == 4'h7
        |-> ##[1:3] powerState == lbc_pkg::PWR_ACT_PD) else $error("no active power-down");
    sr_entry_a: assert property (run && bankStates == 12'h000 ##1 !memCke && pins == 4'h1
        |-> ##[1:3] powerState == lbc_pkg::PWR_SELF_REF) else $error("no self refresh");
    inputs_off_a: assert property (powerState inside {lbc_pkg::PWR_PRE_PD, lbc_pkg::PWR_ACT_PD,
        lbc_pkg::PWR_SELF_REF} |-> !inputsEnabled) else $error("inputs on in low power");
    pd_exit_a: assert property (powerState inside {lbc_pkg::PWR_PRE_PD, lbc_pkg::PWR_ACT_PD}
        && memCke && pins == 4'h7 |-> ##[1:3] powerState inside {lbc_pkg::PWR_PD_EXIT, lbc_pkg::PWR_NORMAL})
        else $error("no power-down exit");
    // Bank states are three-bit fields, bank 0 lowest; 1 means row open
    open_row_a: assert property (run && pins == 4'h3 && memBank == 2'h0 && bankStates[2:0] == 3'h0
        |-> ##[1:3] bankStates[2:0] == 3'h1) else $error("row not opened");
    pch_one_a: assert property (run && pins == 4'h2 && !memAddr[10] && memBank == 2'h1
        && bankStates[8:3] == 6'h09 |-> ##[1:3] bankStates[5:3] != 3'h1 && bankStates[8:6] == 3'h1)
        else $error("wrong bank closed");
    no_act_a: assert property (run && pins == 4'h5 && memBank == 2'h3 && bankStates[11:9] == 3'h0
        |-> ##[1:3] cmdIllegal) else $error("read to idle bank taken");
    burst_flag_a: assert property (bankStates == 12'h000 |-> ##1 !burstActive)
        else $error("burst flag with all banks idle");
    mask_idle_a: assert property (!burstActive |-> !writeMasked)
        else $error("mask flagged outside a burst");
endmodule : lbc_checker
`default_nettype wire

// file: dv/lbc_ctrl_model.sv
// Controller model: drives strobes, clock enable, address and mask
`timescale 1ns/100ps
`default_nettype none
module lbc_ctrl_model (
    input wire logic clk,
    output logic cke,
    output logic [3:0] pins,
    output logic [1:0] bank,
    output logic [12:0] addr,
    output logic dm
);
    // Idle bus: NOP with clock enable high
    initial begin
        cke = 1'b1;
        pins = 4'h7;
        bank = 2'h0;
        addr = 13'h0000;
        dm = 1'b0;
    end
    // One command for one cycle, then NOPs; callers size gaps past precharge, refresh and exit times
    task automatic issue(input logic [3:0] p, input logic [1:0] b, input logic a10, input logic k, input int gap);
        @(posedge clk);
        cke <= k;
        pins <= p;
        bank <= b;
        addr <= {2'($urandom), a10, 10'($urandom)};
        dm <= 1'($urandom);
        @(posedge clk);
        pins <= 4'h7;
        bank <= ~b;
        addr <= ~addr; // Released lines must not keep the last value
        repeat (gap) @(posedge clk);
    endtask : issue
endmodule : lbc_ctrl_model
`default_nettype wire

// file: dv/lbc_testbench.sv
// Self-checking bench for the bank and power sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(act, exp) begin totalChecks++; if ((act) !== (exp)) begin miscompares++; \
    $display("ERROR %0t: got %0h expected %0h", $time, act, exp); end end
module testbench;
    localparam int G = 8;
    localparam logic [3:0] PAT [9] = '{4'hF, 4'h7, 4'h3, 4'h1, 4'h0, 4'h5, 4'h4, 4'h2, 4'h6};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cke;
    logic dm;
    logic [3:0] pins;
    logic [1:0] bank;
    logic [12:0] addr;
    logic [2:0] powerState;
    logic [11:0] bankStates;
    logic inputsEnabled;
    logic cmdValid;
    logic [3:0] cmdCode;
    logic cmdIllegal;
    logic [3:0] got;
    int miscompares = 0;
    int totalChecks = 0;
    int cycles = 0;
    int sawIllegal = 0;
    int seed;
    lbc_pkg::lbc_cmd_e expQ[$];
    lbc_ctrl_model i_ctrl (.clk(clk), .cke(cke), .pins(pins), .bank(bank), .addr(addr), .dm(dm));
    lbc_top i_dut (.clk(clk), .rst_n(rst_n), .memCke(cke), .memCsN(pins[3]), .memRasN(pins[2]),
        .memCasN(pins[1]), .memWeN(pins[0]), .memBank(bank), .memAddr(addr), .memDm(dm),
        .powerState(powerState), .bankStates(bankStates), .inputsEnabled(inputsEnabled),
        .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdIllegal(cmdIllegal), .writeMasked(), .burstActive());
    always #25 clk = ~clk;
    // Hang guard; the whole run needs under two hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            wrapUp();
        end
    end
    // Each flagged command above NOP against the oldest note; an unexpected one compares against F
    always @(negedge clk) begin
        if (cmdIllegal === 1'b1) sawIllegal++;
        if (rst_n && cmdValid === 1'b1 && cmdCode > 4'h1) begin
            got = (expQ.size() > 0) ? 4'(expQ.pop_front()) : 4'hF;
            `CHK(cmdCode, got)
        end
    end
    task automatic send(input lbc_pkg::lbc_cmd_e c, input logic [1:0] b, input logic a, input logic k, input int g);
        if (c > lbc_pkg::CMD_NOP && (k || c == lbc_pkg::CMD_REFRESH)) expQ.push_back(c);
        i_ctrl.issue(PAT[c], b, a, k, g);
    endtask : send
    task automatic look(input logic [11:0] bs, input logic [2:0] ps);
        @(negedge clk);
        `CHK(bankStates, bs)
        `CHK(powerState, ps)
    endtask : look
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrapUp
    initial begin
        seed = $urandom(32'hB3CC);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        // Bank walk: every command code but NOP, with a single NOP cycle between commands where allowed
        send(lbc_pkg::CMD_ACTIVE, 2'h0, 1'b0, 1'b1, G);
        look(12'h001, lbc_pkg::PWR_NORMAL);
        send(lbc_pkg::CMD_READ, 2'h0, 1'b0, 1'b1, 0);
        send(lbc_pkg::CMD_BURST_STOP, 2'h0, 1'b0, 1'b1, G);
        look(12'h001, lbc_pkg::PWR_NORMAL);
        send(lbc_pkg::CMD_WRITE, 2'h0, 1'b0, 1'b1, 0);
        send(lbc_pkg::CMD_PRECHARGE, 2'h0, 1'b0, 1'b1, G);
        look(12'h000, lbc_pkg::PWR_NORMAL);
        send(lbc_pkg::CMD_LOAD_MODE, 2'h0, 1'b0, 1'b1, G);
        send(lbc_pkg::CMD_REFRESH, 2'h0, 1'b0, 1'b1, G);
        send(lbc_pkg::CMD_DESELECT, 2'h0, 1'b0, 1'b1, G);
        $display("bank walk done");
        // One bank versus all banks
        send(lbc_pkg::CMD_ACTIVE, 2'h1, 1'b0, 1'b1, 0);
        send(lbc_pkg::CMD_ACTIVE, 2'h2, 1'b0, 1'b1, G);
        send(lbc_pkg::CMD_PRECHARGE, 2'h1, 1'b0, 1'b1, G);
        look(12'h040, lbc_pkg::PWR_NORMAL);
        send(lbc_pkg::CMD_PRECHARGE, 2'($urandom), 1'b1, 1'b1, G);
        look(12'h000, lbc_pkg::PWR_NORMAL);
        $display("precharge done");
        // Active power-down with garbage while down, then idle power-down and self refresh
        send(lbc_pkg::CMD_ACTIVE, 2'h0, 1'b0, 1'b1, G);
        send(lbc_pkg::CMD_NOP, 2'h0, 1'b0, 1'b0, 2);
        look(12'h001, lbc_pkg::PWR_ACT_PD);
        i_ctrl.issue(4'($urandom), 2'($urandom), 1'($urandom), 1'b0, 2);
        look(12'h001, lbc_pkg::PWR_ACT_PD);
        send(lbc_pkg::CMD_NOP, 2'h0, 1'b0, 1'b1, G);
        look(12'h001, lbc_pkg::PWR_NORMAL);
        send(lbc_pkg::CMD_PRECHARGE, 2'h0, 1'b1, 1'b1, G);
        send(lbc_pkg::CMD_NOP, 2'h0, 1'b0, 1'b0, 2);
        look(12'h000, lbc_pkg::PWR_PRE_PD);
        send(lbc_pkg::CMD_NOP, 2'h0, 1'b0, 1'b1, G);
        look(12'h000, lbc_pkg::PWR_NORMAL);
        send(lbc_pkg::CMD_REFRESH, 2'h0, 1'b0, 1'b0, 4);
        look(12'h000, lbc_pkg::PWR_SELF_REF);
        send(lbc_pkg::CMD_NOP, 2'h0, 1'b0, 1'b1, G);
        look(12'h000, lbc_pkg::PWR_NORMAL);
        $display("power done");
        // Read to an idle bank is refused
        expQ.delete();
        `CHK(sawIllegal, 0)
        send(lbc_pkg::CMD_READ, 2'h3, 1'b0, 1'b1, G);
        `CHK(sawIllegal > 0, 1'b1)
        $display("refusal done");
        wrapUp();
    end
endmodule : testbench
bind lbc_top lbc_checker i_chk (.clk(clk), .rst_n(rst_n), .memCke(memCke), .memCsN(memCsN),
    .memRasN(memRasN), .memCasN(memCasN), .memWeN(memWeN), .memBank(memBank), .memAddr(memAddr),
    .memDm(memDm), .powerState(powerState), .bankStates(bankStates), .inputsEnabled(inputsEnabled),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdIllegal(cmdIllegal), .writeMasked(writeMasked),
    .burstActive(burstActive));
`default_nettype wire
